/* File: include/sapf_pkg.sv */
package sapf_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int SMP_W = 32;
  localparam int POS_W = 11;

  // Register offsets
  localparam logic [7:0] OFS_POL = 8'h31;
  localparam logic [7:0] OFS_FMT = 8'h33;
  localparam logic [7:0] OFS_SHIFT = 8'h34;
  localparam logic [7:0] OFS_ROUTE = 8'h35;
  localparam logic [7:0] OFS_MON = 8'h37;

  // Reset values
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_FMT = 8'h02;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h11;
  localparam logic [7:0] RST_MON = 8'h00;

  // Field positions
  localparam int BIT_CLK_INV = 5;
  localparam int FMT_LSB = 4;
  localparam int PULSE_LSB = 2;
  localparam int WLEN_LSB = 0;
  localparam int SHIFT_HI_BIT = 7;
  localparam int LROUTE_LSB = 4;
  localparam int RROUTE_LSB = 0;
  localparam int MON_RW_LSB = 6;

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_TDM = 2'h1,
    FMT_RJ = 2'h2,
    FMT_LJ = 2'h3
  } sapf_fmt_e;

  typedef enum logic [1:0] {
    WL_16 = 2'h0,
    WL_20 = 2'h1,
    WL_24 = 2'h2,
    WL_32 = 2'h3
  } sapf_wlen_e;

  typedef enum logic [1:0] {
    RT_MUTE = 2'h0,
    RT_SAME = 2'h1,
    RT_SWAP = 2'h2,
    RT_RSVD = 2'h3
  } sapf_route_e;
endpackage

/* File: rtl/sapf_sync.sv */
`timescale 1ns/1ps
module sapf_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          meta_ff[gi] <= 1'b0;
          q_o[gi] <= 1'b0;
        end
        else
        begin
          meta_ff[gi] <= d_i[gi];
          q_o[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
endmodule // sapf_sync

/* File: rtl/sapf_top.sv */
`timescale 1ns/1ps
module sapf_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_sync_i,
  input wire logic serial_data_i,
  input wire logic [sapf_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [sapf_pkg::REG_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [sapf_pkg::REG_DW-1:0] reg_rdata_o,
  output logic [sapf_pkg::SMP_W-1:0] left_sample_o,
  output logic [sapf_pkg::SMP_W-1:0] right_sample_o,
  output logic sample_valid_o
);
  import sapf_pkg::*;

  logic [2:0] pin_s;
  logic bck_s;
  logic fs_s;
  logic din_s;
  logic bck_d_ff;
  logic [7:0] pol_ff;
  logic [7:0] fmt_ff;
  logic [7:0] shift_ff;
  logic [7:0] route_ff;
  logic [7:0] mon_ff;
  logic bit_clock_invert;
  sapf_fmt_e fmt;
  sapf_wlen_e wlen;
  sapf_route_e left_route_select;
  sapf_route_e right_route_select;
  logic [8:0] off_total;
  logic [5:0] wl;
  logic samp_en;
  logic fs_prev_ff;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] half_len_ff;
  logic [SMP_W-1:0] sh_l_ff;
  logic [SMP_W-1:0] sh_r_ff;
  logic fs_edge;
  logic frame_start;
  logic half_start;
  logic cur_left;
  logic [POS_W-1:0] pos_now;
  logic [POS_W-1:0] start_l;
  logic [POS_W-1:0] start_r;
  logic in_l;
  logic in_r;
  logic [SMP_W-1:0] l_al;
  logic [SMP_W-1:0] r_al;

  function automatic logic [5:0] wl_bits(input sapf_wlen_e c);
    case (c)
      WL_16: wl_bits = 6'h10;
      WL_20: wl_bits = 6'h14;
      WL_24: wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction

  // Move the last captured bits to the top of the word
  function automatic logic [SMP_W-1:0] align(input logic [SMP_W-1:0] sh, input logic [5:0] n);
    align = sh << (6'h20 - n);
  endfunction

  function automatic logic in_win(input logic [POS_W-1:0] p, input logic [POS_W-1:0] st,
                                  input logic [5:0] n);
    in_win = (p >= st) && ({1'b0, p} < ({1'b0, st} + {6'h0, n}));
  endfunction

  function automatic logic [SMP_W-1:0] route(input sapf_route_e sel,
                                             input logic [SMP_W-1:0] same,
                                             input logic [SMP_W-1:0] other);
    case (sel)
      RT_SAME: route = same;
      RT_SWAP: route = other;
      default: route = '0;
    endcase
  endfunction

  sapf_sync #(
    .W(3)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({serial_bit_clock_i, frame_sync_i, serial_data_i}),
    .q_o(pin_s)
  );

  assign bck_s = pin_s[2];
  assign fs_s = pin_s[1];
  assign din_s = pin_s[0];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bck_d_ff <= 1'b0;
    else
      bck_d_ff <= bck_s;
  end

  // Host edges fall opposite the sampling edge
  assign samp_en = (bck_s != bck_d_ff) && (bck_s == ~bit_clock_invert);

  // Register file; whole bytes stored so reserved bits read back, except MON, which reads back only bits 7:6
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pol_ff <= RST_POL;
      fmt_ff <= RST_FMT;
      shift_ff <= RST_SHIFT;
      route_ff <= RST_ROUTE;
      mon_ff <= RST_MON;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_POL: pol_ff <= reg_wdata_i;
        OFS_FMT: fmt_ff <= reg_wdata_i;
        OFS_SHIFT: shift_ff <= reg_wdata_i;
        OFS_ROUTE: route_ff <= reg_wdata_i;
        OFS_MON: mon_ff <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_POL: reg_rdata_o <= pol_ff;
        OFS_FMT: reg_rdata_o <= fmt_ff;
        OFS_SHIFT: reg_rdata_o <= shift_ff;
        OFS_ROUTE: reg_rdata_o <= route_ff;
        OFS_MON: reg_rdata_o <= {mon_ff[MON_RW_LSB+:2], 6'h00};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign bit_clock_invert = pol_ff[BIT_CLK_INV];
  assign fmt = sapf_fmt_e'(fmt_ff[FMT_LSB+:2]);
  assign wlen = sapf_wlen_e'(fmt_ff[WLEN_LSB+:2]);
  assign wl = wl_bits(wlen);
  assign off_total = {fmt_ff[SHIFT_HI_BIT], shift_ff};
  assign left_route_select = sapf_route_e'(route_ff[LROUTE_LSB+:2]);
  assign right_route_select = sapf_route_e'(route_ff[RROUTE_LSB+:2]);

  // Frame and half-frame boundaries per format
  always_comb
  begin
    fs_edge = samp_en && (fs_s != fs_prev_ff);
    case (fmt)
      FMT_I2S: frame_start = fs_edge && !fs_s;
      default: frame_start = fs_edge && fs_s;
    endcase
    half_start = (fmt == FMT_TDM) ? frame_start : fs_edge;
    cur_left = (fmt == FMT_I2S) ? !fs_s : fs_s;
    if (half_start)
      pos_now = '0;
    else if (pos_ff == {POS_W{1'b1}})
      pos_now = pos_ff;
    else
      pos_now = pos_ff + 11'h001;
    case (fmt)
      FMT_I2S: start_l = 11'h001 + {2'h0, off_total};
      FMT_RJ: start_l = half_len_ff - {5'h0, wl} + {2'h0, off_total};
      default: start_l = {2'h0, off_total};
    endcase
    start_r = (fmt == FMT_TDM) ? start_l + {5'h0, wl} : start_l;
    in_l = ((fmt == FMT_TDM) || cur_left) && in_win(pos_now, start_l, wl);
    in_r = ((fmt == FMT_TDM) || !cur_left) && in_win(pos_now, start_r, wl);
    l_al = align(sh_l_ff, wl);
    r_al = align(sh_r_ff, wl);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fs_prev_ff <= 1'b0;
      pos_ff <= '0;
      half_len_ff <= '0;
      sh_l_ff <= '0;
      sh_r_ff <= '0;
    end
    else if (samp_en)
    begin
      fs_prev_ff <= fs_s;
      pos_ff <= pos_now;
      if (half_start)
        half_len_ff <= pos_ff + 11'h001;
      if (in_l)
        sh_l_ff <= {sh_l_ff[SMP_W-2:0], din_s};
      if (in_r)
        sh_r_ff <= {sh_r_ff[SMP_W-2:0], din_s};
    end
  end

  // Finished frame leaves through the channel routing
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      left_sample_o <= '0;
      right_sample_o <= '0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= frame_start;
      if (frame_start)
      begin
        left_sample_o <= route(left_route_select, l_al, r_al);
        right_sample_o <= route(right_route_select, r_al, l_al);
      end
    end
  end

  a_edge_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_en |-> ($past(pin_s[2]) != pin_s[2]) && (pin_s[2] != pol_ff[BIT_CLK_INV]))
    else $error("sampling edge does not follow bit clock polarity");

  a_word_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wl == ((fmt_ff[1:0] == 2'h0) ? 6'h10 : (fmt_ff[1:0] == 2'h1) ? 6'h14 :
           (fmt_ff[1:0] == 2'h2) ? 6'h18 : 6'h20))
    else $error("word length code maps to wrong bit count");

  a_i2s_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fmt_ff[5:4] == 2'h0) |-> start_l == {2'h0, fmt_ff[7], shift_ff} + 11'h001)
    else $error("i2s sample does not begin one clock after the boundary plus offset");

  a_lj_offset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fmt_ff[5:4] == 2'h3) |-> start_l == {2'h0, fmt_ff[7], shift_ff})
    else $error("left-justified start differs from programmed offset");

  a_tdm_slots: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fmt_ff[5:4] == 2'h1) |-> start_r == start_l + {5'h0, wl})
    else $error("tdm right slot not adjacent to left slot");

  a_left_mute: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_valid_o && ($past(route_ff[5:4]) == 2'h0) |-> left_sample_o == 32'h0)
    else $error("left channel not muted");

  a_left_swap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_valid_o && ($past(route_ff[5:4]) == 2'h2) |-> left_sample_o == $past(r_al))
    else $error("left channel did not take right data");

  a_right_same: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_valid_o && ($past(route_ff[1:0]) == 2'h1) |-> right_sample_o == $past(r_al))
    else $error("right channel did not take right data");

  a_right_swap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_valid_o && ($past(route_ff[1:0]) == 2'h2) |-> right_sample_o == $past(l_al))
    else $error("right channel did not take left data");

  a_reserved_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && (reg_addr_i == OFS_POL) ##1 !reg_wr_i
    ##1 reg_rd_i && (reg_addr_i == OFS_POL) && !reg_wr_i
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("polarity register did not read back as written");
endmodule // sapf_top

/* File: tb/sapf_host_model.sv */
`timescale 1ns/1ps
module sapf_host_model (
  input wire logic inv_i,
  output logic bck_o,
  output logic fs_o,
  output logic sd_o
);
  initial
  begin
    bck_o = 1'b1;
    fs_o = 1'b0;
    sd_o = 1'b0;
  end

  // One 64-clock frame, 32 clocks per half; clock stands still after it
  task automatic frame(input logic [1:0] fmt, input int wl, input int ofs,
                       input logic [31:0] l, input logic [31:0] r);
    int p, k, st;
    logic lvl, b;
    logic [31:0] w;
    begin
      lvl = (fmt != 2'h0);
      fs_o = ~lvl;
      bck_o = ~inv_i;
      for (p = 0; p < 64; p++)
      begin
        k = (p < 32) ? p : p - 32;
        w = (p < 32) ? l : r;
        st = (fmt == 2'h0) ? 1 + ofs : (fmt == 2'h2) ? 32 - wl + ofs : ofs;
        if (fmt == 2'h1)
        begin
          k = p;
          w = (p < ofs + wl) ? l : r;
          st = (p < ofs + wl) ? ofs : ofs + wl;
        end
        b = p[0];
        if (k >= st && k < st + wl)
          b = w[wl - 1 - (k - st)];
        // Launch on the edge opposite to sampling
        bck_o = inv_i;
        fs_o = (p < 32) ? lvl : ~lvl;
        sd_o = b;
        #80;
        bck_o = ~inv_i;
        #80;
      end
      sd_o = ~sd_o;
    end
  endtask
endmodule // sapf_host_model

/* File: tb/sapf_top_tb_top.sv */
`timescale 1ns/1ps
module sapf_top_tb_top;
  import sapf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic serial_bit_clock, fs, sd, wr, rd, inv, sv;
  logic [7:0] addr, wdata, rdata;
  logic [31:0] ls, rs, cap_l, cap_r;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] ofs_a [5] = '{OFS_POL, OFS_FMT, OFS_SHIFT, OFS_ROUTE, OFS_MON};
  logic [7:0] rst_a [5] = '{RST_POL, RST_FMT, RST_SHIFT, RST_ROUTE, RST_MON};
  logic [7:0] wv_a [5] = '{8'hff, 8'hff, 8'hff, 8'hee, 8'hff};
  logic [7:0] ff_a [5] = '{8'hff, 8'hff, 8'hff, 8'hee, 8'hc0};

  always #2.5 ref_clk_i = ~ref_clk_i;

  sapf_top u_sapf_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .serial_bit_clock_i(serial_bit_clock),
    .frame_sync_i(fs), .serial_data_i(sd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .left_sample_o(ls),
    .right_sample_o(rs), .sample_valid_o(sv));

  sapf_host_model u_sapf_host_model (.inv_i(inv), .bck_o(serial_bit_clock), .fs_o(fs), .sd_o(sd));

  always @(posedge ref_clk_i)
    if (sv === 1'b1)
    begin
      cap_l <= ls;
      cap_r <= rs;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge ref_clk_i);
    #1 wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    #1 addr = a;
    rd = 1'b1;
    @(posedge ref_clk_i);
    #1 rd = 1'b0;
    chk({24'h0, rdata}, {24'h0, exp});
  endtask

  // Three frames; the pair of the second one is kept in cap_l/cap_r
  task automatic run(input sapf_fmt_e f, input sapf_wlen_e w, input logic [8:0] o,
                     input sapf_route_e lr, input sapf_route_e rr,
                     input logic [31:0] l, input logic [31:0] r);
    int wl;
    logic [31:0] lm, rm, el, er;
    wl = (w == WL_32) ? 32 : 16 + 4 * int'(w);
    wr_reg(OFS_FMT, {o[8], 1'b0, f, 2'h0, w});
    wr_reg(OFS_SHIFT, o[7:0]);
    wr_reg(OFS_ROUTE, {2'h0, lr, 2'h0, rr});
    repeat (3) u_sapf_host_model.frame(f, wl, int'(o), l, r);
    repeat (4) @(posedge ref_clk_i);
    lm = l << (32 - wl);
    rm = r << (32 - wl);
    el = (lr == RT_SAME) ? lm : (lr == RT_SWAP) ? rm : 32'h0;
    er = (rr == RT_SAME) ? rm : (rr == RT_SWAP) ? lm : 32'h0;
    chk(cap_l, el);
    chk(cap_r, er);
  endtask

  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    inv = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk(ls, 32'h0);
    for (int i = 0; i < 5; i++)
      rd_reg(ofs_a[i], rst_a[i]);
    for (int i = 0; i < 5; i++)
      wr_reg(ofs_a[i], wv_a[i]);
    for (int i = 0; i < 5; i++)
      rd_reg(ofs_a[i], ff_a[i]);
    wr_reg(8'h32, 8'hff);
    rd_reg(8'h32, 8'h00);
    for (int i = 0; i < 5; i++)
      wr_reg(ofs_a[i], rst_a[i]);
    run(FMT_LJ, WL_16, 9'h0, RT_SAME, RT_SAME, 32'h1234, 32'habcd);
    run(FMT_I2S, WL_24, 9'h3, RT_SAME, RT_SAME, 32'h5a3c96, 32'ha5c369);
    run(FMT_RJ, WL_20, 9'h0, RT_SAME, RT_SAME, 32'h9e371, 32'h4c1d2);
    inv = 1'b1;
    wr_reg(OFS_POL, 8'hff);
    rd_reg(OFS_POL, 8'hff);
    run(FMT_TDM, WL_24, 9'h5, RT_SAME, RT_SAME, 32'hc0ffee, 32'h13579b);
    inv = 1'b0;
    wr_reg(OFS_POL, 8'h00);
    run(FMT_LJ, WL_32, 9'h0, RT_MUTE, RT_SWAP, 32'h8765_4321, 32'h0f1e_2d3c);
    run(FMT_LJ, WL_32, 9'h0, RT_SWAP, RT_MUTE, 32'h8765_4321, 32'h0f1e_2d3c);
    run(FMT_LJ, WL_32, 9'h0, RT_SWAP, RT_SWAP, 32'h8765_4321, 32'h0f1e_2d3c);
    stop_test();
  end
endmodule // sapf_top_tb_top
